// File: pkg/mmc_defs.svh
// Constants for the measurement mode control block
`ifndef MMC_DEFS_SVH
`define MMC_DEFS_SVH

// Boot and typical conversion times in nanoseconds
`define MMC_BOOT_TIME_NS 64'd4500000
`define MMC_CONV_LOW_NOISE_NS 64'd13200000
`define MMC_CONV_LOW_CURRENT_NS 64'd4700000
`define MMC_NS_PER_S 64'd1000000000

// Rate field codes
`define MMC_RATE_OFF 3'h0
`define MMC_RATE_1HZ 3'h1
`define MMC_RATE_10HZ 3'h2
`define MMC_RATE_25HZ 3'h3
`define MMC_RATE_50HZ 3'h4
`define MMC_RATE_75HZ 3'h5
`define MMC_RATE_100HZ 3'h6
`define MMC_RATE_200HZ 3'h7

// Continuous sampling frequencies in hertz
`define MMC_HZ_1 32'd1
`define MMC_HZ_10 32'd10
`define MMC_HZ_25 32'd25
`define MMC_HZ_50 32'd50
`define MMC_HZ_75 32'd75
`define MMC_HZ_100 32'd100
`define MMC_HZ_200 32'd200

// Counter width and reset values
`define MMC_CNT_W 27
`define MMC_RESET_PRESS 24'h000000
`define MMC_RESET_TEMP 16'h0000

`endif

// File: pkg/mmc_pkg.sv
// Types for the measurement mode control block
`default_nettype none
`include "mmc_defs.svh"
package mmc_pkg;

    // Operating modes
    typedef enum logic [1:0] {MMC_BOOT, MMC_POWER_DOWN, MMC_SINGLE, MMC_CONTINUOUS} mmc_mode_type;

    // One sample of pressure and temperature
    typedef struct packed {
        logic [23:0] press;
        logic [15:0] temp;
    } mmc_sample_type;

    // Whole state of the block
    typedef struct packed {
        mmc_mode_type mode;
        logic [`MMC_CNT_W-1:0] cnt;
        logic [2:0] rateSeen;
        logic captureReq;
        logic lowNoise;
        logic updated;
        mmc_sample_type data;
    } mmc_state_type;

endpackage : mmc_pkg
`default_nettype wire

// File: rtl/mmc_measurement_mode_control.sv
// Mode sequencer: boot, power-down, single capture and continuous sampling
//
// What this block does
// - Boot at most 4.5 ms, then power-down
// - Power-down: no acquisition, interface stays alive
// - Power-down keeps config, freezes output data
// - Rate field zero means power-down
// - Single capture: one sample, self-clear, power-down
// - Single capture timing set by noise setting
// - Non-zero rate starts continuous sampling at once
// - Rate codes map to 1 to 200 Hz
// - Noise bit: zero low-current, one low-noise
`timescale 1ns/1ps
`default_nettype none
`include "mmc_defs.svh"

module mmc_measurement_mode_control #(
    parameter longint CLK_HZ = 64'd25000000
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic [2:0] rateSelect, // Rate select field
    input wire logic lowNoiseSelect, // Noise setting bit
    input wire logic captureStrobe, // Write of one to capture request
    input wire mmc_pkg::mmc_sample_type sensorSample, // Converter result
    output logic captureReq, // Single capture request bit
    output logic interfaceReady, // Boot finished
    output logic sensorPowered, // Acquisition chain on
    output logic lowNoiseActive, // Applied noise setting
    output logic dataUpdated, // Output data refreshed, pulse
    output mmc_pkg::mmc_sample_type outData // Output data registers
);

    // Cycle counts derived from times and clock rate, rounded down
    localparam longint BOOT_CYC_L = `MMC_BOOT_TIME_NS * CLK_HZ / `MMC_NS_PER_S;
    localparam longint CONV_LN_L = `MMC_CONV_LOW_NOISE_NS * CLK_HZ / `MMC_NS_PER_S;
    localparam longint CONV_LC_L = `MMC_CONV_LOW_CURRENT_NS * CLK_HZ / `MMC_NS_PER_S;
    localparam logic [`MMC_CNT_W-1:0] BOOT_CYC = `MMC_CNT_W'(BOOT_CYC_L);
    localparam logic [`MMC_CNT_W-1:0] CONV_LN_CYC = `MMC_CNT_W'(CONV_LN_L);
    localparam logic [`MMC_CNT_W-1:0] CONV_LC_CYC = `MMC_CNT_W'(CONV_LC_L);

    // Refuse clock rates the counter cannot hold or that give zero counts
    if (CLK_HZ >= (64'd1 << `MMC_CNT_W) || CLK_HZ < 64'd200 || CONV_LC_L < 64'd1
        || BOOT_CYC_L < 64'd1)
    begin : gen_bad_clk
        $error("mmc: CLK_HZ out of range");
    end

    // Period of one continuous sample, minus one, per rate code
    function automatic logic [`MMC_CNT_W-1:0] periodCycles(input logic [2:0] rate);
        logic [31:0] hz;
        unique case (rate)
            `MMC_RATE_1HZ: hz = `MMC_HZ_1;
            `MMC_RATE_10HZ: hz = `MMC_HZ_10;
            `MMC_RATE_25HZ: hz = `MMC_HZ_25;
            `MMC_RATE_50HZ: hz = `MMC_HZ_50;
            `MMC_RATE_75HZ: hz = `MMC_HZ_75;
            `MMC_RATE_100HZ: hz = `MMC_HZ_100;
            `MMC_RATE_200HZ: hz = `MMC_HZ_200;
            default: hz = `MMC_HZ_1;
        endcase
        return `MMC_CNT_W'(CLK_HZ / hz - 64'd1);
    endfunction : periodCycles

    // Conversion length of one single capture, minus one
    function automatic logic [`MMC_CNT_W-1:0] convCycles(input logic lowNoise);
        return lowNoise ? CONV_LN_CYC - `MMC_CNT_W'(1) : CONV_LC_CYC - `MMC_CNT_W'(1);
    endfunction : convCycles

    mmc_pkg::mmc_state_type st;
    mmc_pkg::mmc_state_type next_st;

    // Next-state logic
    always_comb
    begin
        next_st = st;
        next_st.updated = 1'b0;
        unique case (st.mode)
            mmc_pkg::MMC_BOOT:
            begin
                if (st.cnt == '0)
                begin
                    next_st.mode = mmc_pkg::MMC_POWER_DOWN;
                end
                else
                begin
                    next_st.cnt = st.cnt - `MMC_CNT_W'(1);
                end
            end
            mmc_pkg::MMC_POWER_DOWN:
            begin
                // Noise bit follows the host only while idle
                next_st.lowNoise = lowNoiseSelect;
                if (rateSelect != `MMC_RATE_OFF)
                begin
                    next_st.mode = mmc_pkg::MMC_CONTINUOUS;
                    next_st.rateSeen = rateSelect;
                    next_st.cnt = periodCycles(rateSelect);
                end
                else if (captureStrobe)
                begin
                    // Capture accepted only here
                    next_st.mode = mmc_pkg::MMC_SINGLE;
                    next_st.captureReq = 1'b1;
                    next_st.cnt = convCycles(lowNoiseSelect);
                end
            end
            mmc_pkg::MMC_SINGLE:
            begin
                if (rateSelect != `MMC_RATE_OFF)
                begin
                    // Rate write overrides a pending capture
                    next_st.mode = mmc_pkg::MMC_CONTINUOUS;
                    next_st.captureReq = 1'b0;
                    next_st.rateSeen = rateSelect;
                    next_st.cnt = periodCycles(rateSelect);
                end
                else if (st.cnt == '0)
                begin
                    next_st.data = sensorSample;
                    next_st.updated = 1'b1;
                    next_st.captureReq = 1'b0;
                    next_st.mode = mmc_pkg::MMC_POWER_DOWN;
                end
                else
                begin
                    next_st.cnt = st.cnt - `MMC_CNT_W'(1);
                end
            end
            mmc_pkg::MMC_CONTINUOUS:
            begin
                if (rateSelect == `MMC_RATE_OFF)
                begin
                    next_st.mode = mmc_pkg::MMC_POWER_DOWN;
                end
                else if (rateSelect != st.rateSeen)
                begin
                    // New rate restarts the period
                    next_st.rateSeen = rateSelect;
                    next_st.cnt = periodCycles(rateSelect);
                end
                else if (st.cnt == '0)
                begin
                    next_st.data = sensorSample;
                    next_st.updated = 1'b1;
                    next_st.cnt = periodCycles(st.rateSeen);
                end
                else
                begin
                    next_st.cnt = st.cnt - `MMC_CNT_W'(1);
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st.mode <= mmc_pkg::MMC_BOOT;
            st.cnt <= BOOT_CYC - `MMC_CNT_W'(1);
            st.rateSeen <= `MMC_RATE_OFF;
            st.captureReq <= 1'b0;
            st.lowNoise <= 1'b0;
            st.updated <= 1'b0;
            st.data <= {`MMC_RESET_PRESS, `MMC_RESET_TEMP};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs
    assign captureReq = st.captureReq;
    assign interfaceReady = (st.mode != mmc_pkg::MMC_BOOT);
    assign sensorPowered = (st.mode == mmc_pkg::MMC_SINGLE)
                           || (st.mode == mmc_pkg::MMC_CONTINUOUS);
    assign lowNoiseActive = st.lowNoise;
    assign dataUpdated = st.updated;
    assign outData = st.data;

    // Checks
    AST_BOOT_END: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_BOOT && st.cnt == '0) |=> st.mode == mmc_pkg::MMC_POWER_DOWN)
        else $error("boot did not end in power-down");
    AST_PD_FROZEN: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_POWER_DOWN) ##1 (st.mode == mmc_pkg::MMC_POWER_DOWN)
        |-> $stable(outData) && !dataUpdated)
        else $error("output data changed in power-down");
    AST_PD_QUIET: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_POWER_DOWN) |-> !sensorPowered && interfaceReady)
        else $error("acquisition active in power-down");
    AST_RATE_ZERO: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_CONTINUOUS && rateSelect == `MMC_RATE_OFF)
        |=> st.mode == mmc_pkg::MMC_POWER_DOWN)
        else $error("zero rate did not stop sampling");
    AST_CAPTURE_START: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_POWER_DOWN && rateSelect == `MMC_RATE_OFF && captureStrobe)
        |=> st.mode == mmc_pkg::MMC_SINGLE && captureReq)
        else $error("capture request not taken");
    AST_CAPTURE_DONE: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_SINGLE && st.cnt == '0 && rateSelect == `MMC_RATE_OFF)
        |=> st.mode == mmc_pkg::MMC_POWER_DOWN && !captureReq && dataUpdated
        && outData == $past(sensorSample))
        else $error("single capture did not finish correctly");
    AST_CAPTURE_LEN: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_POWER_DOWN && rateSelect == `MMC_RATE_OFF && captureStrobe)
        |=> st.cnt == (lowNoiseActive ? CONV_LN_CYC : CONV_LC_CYC) - `MMC_CNT_W'(1))
        else $error("conversion length wrong");
    AST_RATE_START: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_POWER_DOWN && rateSelect != `MMC_RATE_OFF)
        |=> st.mode == mmc_pkg::MMC_CONTINUOUS && st.cnt == periodCycles($past(rateSelect)))
        else $error("continuous mode not entered");
    AST_CONT_SAMPLE: assert property (@(posedge clk) disable iff (rst)
        (st.mode == mmc_pkg::MMC_CONTINUOUS && st.cnt == '0 && rateSelect == st.rateSeen)
        |=> dataUpdated && st.cnt == periodCycles(st.rateSeen))
        else $error("continuous sample missed");
    AST_NOISE_HOLD: assert property (@(posedge clk) disable iff (rst)
        (st.mode != mmc_pkg::MMC_POWER_DOWN) |=> $stable(lowNoiseActive))
        else $error("noise setting changed outside power-down");

endmodule : mmc_measurement_mode_control
`default_nettype wire

// File: testbench/mmc_host_model.sv
// Host model driving the mode fields of the sequencer
`timescale 1ns/1ps
`default_nettype none

module mmc_host_model (
    input wire logic clk, // Block clock
    input wire logic sensorPowered, // Acquisition chain on
    output logic [2:0] rateSelect, // Rate field
    output logic lowNoiseSelect, // Noise bit
    output logic captureStrobe // Capture write pulse
);
    // Idle host after power-up
    initial
    begin
        rateSelect = 3'h0;
        lowNoiseSelect = 1'h0;
        captureStrobe = 1'h0;
    end

    // Noise bit moves only while the chain is off
    task automatic setNoise(input logic ln);
        while (sensorPowered !== 1'b0) @(negedge clk);
        @(negedge clk);
        lowNoiseSelect = ln;
    endtask : setNoise

    // Fast rates need low-current setting first
    task automatic setRate(input logic [2:0] r);
        if (r == 3'h6 || r == 3'h7) setNoise(1'b0);
        @(negedge clk);
        rateSelect = r;
    endtask : setRate

    // Capture request only from power-down
    task automatic capture();
        while (sensorPowered !== 1'b0 || rateSelect != 3'h0) @(negedge clk);
        @(negedge clk);
        captureStrobe = 1'b1;
        @(negedge clk);
        captureStrobe = 1'b0;
    endtask : capture
endmodule : mmc_host_model
`default_nettype wire

// File: testbench/mmc_measurement_mode_control_tb_top.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
`default_nettype none

module mmc_measurement_mode_control_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] rateSelect;
    logic lowNoiseSelect, captureStrobe, captureReq, interfaceReady;
    logic sensorPowered, lowNoiseActive, dataUpdated;
    mmc_pkg::mmc_sample_type sensorSample = 40'h0;
    mmc_pkg::mmc_sample_type outData;
    int errors = 0;
    int n_compared = 0;
    int hzTab[7] = '{1, 10, 25, 50, 75, 100, 200};

    // Clock at 25 MHz
    always #20 clk = ~clk;

    mmc_measurement_mode_control #(.CLK_HZ(64'd1000)) dut_u (.clk(clk), .rst(rst),
        .rateSelect(rateSelect), .lowNoiseSelect(lowNoiseSelect),
        .captureStrobe(captureStrobe), .sensorSample(sensorSample), .captureReq(captureReq),
        .interfaceReady(interfaceReady), .sensorPowered(sensorPowered),
        .lowNoiseActive(lowNoiseActive), .dataUpdated(dataUpdated), .outData(outData));
    mmc_host_model host_u (.clk(clk), .sensorPowered(sensorPowered), .rateSelect(rateSelect),
        .lowNoiseSelect(lowNoiseSelect), .captureStrobe(captureStrobe));

    // Comparison helpers
    task automatic cmpBit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask : cmpBit
    task automatic cmpData(input mmc_pkg::mmc_sample_type got, input mmc_pkg::mmc_sample_type exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: data got %h expected %h", $time, got, exp);
        end
    endtask : cmpData

    // Count falling edges until an update pulse, bounded
    task automatic waitUpd(input int lim, output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (dataUpdated !== 1'b1 && n < lim);
    endtask : waitUpd

    // Boot then power-down
    task automatic testBoot();
        int n;
        cmpBit(interfaceReady, 1'b0);
        for (n = 0; n < 6 && interfaceReady !== 1'b1; n++) @(negedge clk);
        cmpBit(interfaceReady, 1'b1);
        cmpBit(sensorPowered, 1'b0);
        $display("test boot done");
    endtask : testBoot

    // Single capture in either noise setting
    task automatic testSingle(input logic ln, input int conv);
        int n;
        host_u.setNoise(ln);
        sensorSample = {ln ? 24'hA5C3E1 : 24'h1B2D3F, 16'h7E81};
        host_u.capture();
        cmpBit(captureReq, 1'b1);
        waitUpd(40, n);
        cmpBit(n >= conv && n <= conv + 2, 1'b1);
        cmpData(outData, sensorSample);
        cmpBit(captureReq, 1'b0);
        @(negedge clk);
        cmpBit(sensorPowered, 1'b0);
        cmpBit(lowNoiseActive, ln);
        $display("test single done");
    endtask : testSingle

    // Power-down freezes the output data
    task automatic testFreeze();
        mmc_pkg::mmc_sample_type held;
        int n;
        held = outData;
        sensorSample = 40'hFFFFFF0000;
        waitUpd(30, n);
        cmpBit(dataUpdated, 1'b0);
        cmpData(outData, held);
        $display("test freeze done");
    endtask : testFreeze

    // Every rate code gives its period
    task automatic testRates();
        int i;
        int n;
        for (i = 1; i < 8; i++)
        begin
            sensorSample = {21'h0, i[2:0], 16'hC0DE};
            host_u.setRate(i[2:0]);
            @(negedge clk);
            cmpBit(sensorPowered, 1'b1);
            waitUpd(1100, n);
            waitUpd(1100, n);
            cmpBit(n == 1000 / hzTab[i - 1], 1'b1);
            cmpData(outData, sensorSample);
            host_u.setRate(3'h0);
            @(negedge clk);
            @(negedge clk);
            cmpBit(sensorPowered, 1'b0);
        end
        $display("test rates done");
    endtask : testRates

    // Rate change while sampling, and rate write aborting a capture
    task automatic testSwitch();
        int n;
        sensorSample = 40'h123456ABCD;
        host_u.setRate(3'h7);
        waitUpd(20, n);
        host_u.setRate(3'h5);
        waitUpd(40, n);
        waitUpd(40, n);
        cmpBit(n == 1000 / hzTab[4], 1'b1);
        host_u.setRate(3'h0);
        host_u.capture();
        cmpBit(captureReq, 1'b1);
        host_u.setRate(3'h2);
        @(negedge clk);
        cmpBit(captureReq, 1'b0);
        cmpBit(sensorPowered, 1'b1);
        waitUpd(300, n);
        cmpBit(n == 1000 / hzTab[1], 1'b1);
        cmpData(outData, sensorSample);
        host_u.setRate(3'h0);
        @(negedge clk);
        @(negedge clk);
        cmpBit(sensorPowered, 1'b0);
        $display("test switch done");
    endtask : testSwitch

    // Verdict and end of run
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        testBoot();
        testSingle(1'b0, 4);
        testSingle(1'b1, 13);
        testFreeze();
        testRates();
        testSwitch();
        testFreeze();
        final_report();
    end
endmodule : mmc_measurement_mode_control_tb_top
`default_nettype wire
